// ---- src/mcs_regs.v ----
`timescale 1ns/1ps
`include "mcs_consts.vh"

module mcs_regs #(
    parameter ADDR_W = `MCS_ADDR_W
) (
    // Clock and reset
    input  wire              clk,
    input  wire              rst_b,
    // Register port from serial interface logic
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire [15:0]       reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [15:0]       reg_rdata,
    output reg               reg_rvalid,
    // GPIO output levels
    output wire [7:0]        pin_out_level,
    // DAC output power, high keeps output on
    output wire [11:0]       analog_out_on,
    // Converter side
    output wire              conv_start,
    output wire [4:0]        conv_channel,
    input  wire              conv_done,
    input  wire [9:0]        local_temp_data,
    input  wire              local_temp_load,
    input  wire [9:0]        remote_temp_data,
    input  wire              remote_temp_load,
    input  wire [7:0]        input_over_trip,
    // Alarm
    output reg               alarm
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg  [7:0]  gpio_output_levels;
    reg  [7:0]  analog_scan_enable_low;
    reg  [7:0]  analog_scan_enable_high;
    reg         local_scan_on;
    reg         remote_scan_on;
    reg  [15:0] dac_output_power;
    reg  [9:0]  local_temperature_result;
    reg  [9:0]  remote_temperature_result;
    reg  [7:0]  input_high_flags_low;
    reg  [7:0]  input_over_mask;
    reg         monitor_start;
    reg         alarm_global_mask;
    reg         alarm_ack;

    reg  [15:0] next_rdata;
    wire [7:0]  next_flags;
    reg         next_ack;
    reg         next_alarm;

    wire        rd_status;
    wire [7:0]  live_flags;
    wire [`MCS_NUM_CHAN-1:0] scan_enables;
    wire        wr_gpio;
    wire        wr_scan_low;
    wire        wr_scan_high;
    wire        wr_scan_temp;
    wire        wr_dac;
    wire        wr_mask;
    wire        wr_config;
    genvar      gi;

    // Address match used for both write and read decode
    function hit;
        input [ADDR_W-1:0] addr;
        input [7:0]        off;
        begin
            hit = (addr == off[ADDR_W-1:0]);
        end
    endfunction

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    assign rd_status    = reg_rd && hit(reg_addr, `MCS_OFF_OVER_FLAGS);

    // Read-only and unmapped offsets have no write strobe
    assign wr_gpio      = reg_wr && hit(reg_addr, `MCS_OFF_GPIO_OUT);
    assign wr_scan_low  = reg_wr && hit(reg_addr, `MCS_OFF_SCAN_LOW);
    assign wr_scan_high = reg_wr && hit(reg_addr, `MCS_OFF_SCAN_HIGH);
    assign wr_scan_temp = reg_wr && hit(reg_addr, `MCS_OFF_SCAN_TEMP);
    assign wr_dac       = reg_wr && hit(reg_addr, `MCS_OFF_DAC_POWER);
    assign wr_mask      = reg_wr && hit(reg_addr, `MCS_OFF_OVER_MASK);
    assign wr_config    = reg_wr && hit(reg_addr, `MCS_OFF_CONFIG);

    // ----------------------------------------------------------------
    // Write side
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            gpio_output_levels      <= `MCS_RST_GPIO_OUT;
            analog_scan_enable_low  <= `MCS_RST_SCAN;
            analog_scan_enable_high <= `MCS_RST_SCAN;
            local_scan_on           <= `MCS_RST_TEMP_EN;
            remote_scan_on          <= `MCS_RST_TEMP_EN;
            dac_output_power        <= `MCS_RST_DAC_POWER;
            input_over_mask         <= `MCS_RST_MASK;
            monitor_start           <= `MCS_RST_START;
            alarm_global_mask       <= `MCS_RST_GLOBAL_MASK;
        end else begin
            // Only the low byte of narrow registers is stored
            if (wr_gpio) begin
                gpio_output_levels <= reg_wdata[7:0];
            end
            if (wr_scan_low) begin
                analog_scan_enable_low <= reg_wdata[7:0];
            end
            if (wr_scan_high) begin
                analog_scan_enable_high <= reg_wdata[7:0];
            end
            if (wr_scan_temp) begin
                local_scan_on  <= reg_wdata[`MCS_LOCAL_EN_BIT];
                remote_scan_on <= reg_wdata[`MCS_REMOTE_EN_BIT];
            end
            if (wr_dac) begin
                dac_output_power <= reg_wdata;
            end
            if (wr_mask) begin
                input_over_mask <= reg_wdata[7:0];
            end
            if (wr_config) begin
                monitor_start     <= reg_wdata[`MCS_CFG_START_BIT];
                alarm_global_mask <= reg_wdata[`MCS_CFG_MASK_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin and DAC outputs
    // ----------------------------------------------------------------
    assign pin_out_level = gpio_output_levels;

    // Outputs 1-6 sit in bits 5:0, outputs 7-12 in bits 13:8
    generate
        for (gi = 0; gi < 12; gi = gi + 1) begin : g_dac
            assign analog_out_on[gi] = dac_output_power[gi + 2 * (gi / 6)];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Temperature results from the converter
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            local_temperature_result  <= `MCS_RST_TEMP;
            remote_temperature_result <= `MCS_RST_TEMP;
        end else begin
            if (local_temp_load) begin
                local_temperature_result <= local_temp_data;
            end
            if (remote_temp_load) begin
                remote_temperature_result <= remote_temp_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // Over-limit flags and alarm
    // ----------------------------------------------------------------
    // A trip in the clearing cycle survives; set beats clear
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
            assign next_flags[gi] = (input_high_flags_low[gi] & ~rd_status)
                                  | input_over_trip[gi];
            assign live_flags[gi] = next_flags[gi] & ~input_over_mask[gi];
        end
    endgenerate

    // Acknowledge drops the alarm until a fresh trip arrives
    always @* begin
        next_ack = alarm_ack;
        if (rd_status) begin
            next_ack = 1'b1;
        end
        if (|input_over_trip) begin
            next_ack = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Alarm output
    // ----------------------------------------------------------------
    // Alarm comes from a flop, so the pin never shows a decode glitch
    always @* begin
        next_alarm = (|live_flags) && !next_ack && !alarm_global_mask;
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            input_high_flags_low <= `MCS_RST_FLAGS;
            alarm_ack            <= 1'b0;
            alarm                <= 1'b0;
        end else begin
            input_high_flags_low <= next_flags;
            alarm_ack            <= next_ack;
            alarm                <= next_alarm;
        end
    end

    // ----------------------------------------------------------------
    // Read side
    // ----------------------------------------------------------------
    // Returns the flags as they stood before this read's clear
    always @* begin
        next_rdata = 16'h0000;
        case (reg_addr)
            `MCS_OFF_CONFIG: begin
                next_rdata[`MCS_CFG_START_BIT] = monitor_start;
                next_rdata[`MCS_CFG_MASK_BIT]  = alarm_global_mask;
            end
            `MCS_OFF_GPIO_OUT: begin
                next_rdata[7:0] = gpio_output_levels;
            end
            `MCS_OFF_SCAN_LOW: begin
                next_rdata[7:0] = analog_scan_enable_low;
            end
            `MCS_OFF_SCAN_HIGH: begin
                next_rdata[7:0] = analog_scan_enable_high;
            end
            `MCS_OFF_SCAN_TEMP: begin
                next_rdata[`MCS_LOCAL_EN_BIT]  = local_scan_on;
                next_rdata[`MCS_REMOTE_EN_BIT] = remote_scan_on;
            end
            `MCS_OFF_DAC_POWER: begin
                next_rdata = dac_output_power;
            end
            `MCS_OFF_UNUSED: begin
                next_rdata = 16'h0000;
            end
            `MCS_OFF_LOCAL_TEMP: begin
                next_rdata[`MCS_TEMP_MSB:0] = local_temperature_result;
            end
            `MCS_OFF_REMOTE_TEMP: begin
                next_rdata[`MCS_TEMP_MSB:0] = remote_temperature_result;
            end
            `MCS_OFF_OVER_FLAGS: begin
                next_rdata[7:0] = input_high_flags_low;
            end
            `MCS_OFF_OVER_MASK: begin
                next_rdata[7:0] = input_over_mask;
            end
            default: begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            // Read data holds until the next read strobe
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Round-robin sequencer
    // ----------------------------------------------------------------
    // Channel order seen by the sequencer: analog 1-16, local, remote
    assign scan_enables = {remote_scan_on,
                           local_scan_on,
                           analog_scan_enable_high,
                           analog_scan_enable_low};

    mcs_scan #(
        .NUM_CHAN (`MCS_NUM_CHAN),
        .CHAN_W   (`MCS_CHAN_W)
    ) u_scan (
        .clk          (clk),
        .rst_b        (rst_b),
        .run          (monitor_start),
        .chan_en      (scan_enables),
        .conv_start   (conv_start),
        .conv_channel (conv_channel),
        .conv_done    (conv_done)
    );

endmodule

// ---- pkg/mcs_consts.vh ----
`ifndef MCS_CONSTS_VH
`define MCS_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MCS_ADDR_W          8
`define MCS_OFF_CONFIG      8'h01
`define MCS_OFF_GPIO_OUT    8'h08
`define MCS_OFF_SCAN_LOW    8'h09
`define MCS_OFF_SCAN_HIGH   8'h0a
`define MCS_OFF_SCAN_TEMP   8'h0b
`define MCS_OFF_DAC_POWER   8'h0c
`define MCS_OFF_UNUSED      8'h0d
`define MCS_OFF_LOCAL_TEMP  8'h0e
`define MCS_OFF_REMOTE_TEMP 8'h0f
`define MCS_OFF_OVER_FLAGS  8'h10
`define MCS_OFF_OVER_MASK   8'h15

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MCS_CFG_START_BIT   0
`define MCS_CFG_MASK_BIT    6
`define MCS_LOCAL_EN_BIT    7
`define MCS_REMOTE_EN_BIT   6
`define MCS_TEMP_MSB        9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MCS_RST_GPIO_OUT    8'h00
`define MCS_RST_SCAN        8'hff
`define MCS_RST_TEMP_EN     1'b1
`define MCS_RST_DAC_POWER   16'hffff
`define MCS_RST_TEMP        10'h000
`define MCS_RST_FLAGS       8'h00
`define MCS_RST_MASK        8'hff
`define MCS_RST_START       1'b1
`define MCS_RST_GLOBAL_MASK 1'b0

// ----------------------------------------------------------------
// Scan channel numbering: 0..15 analog, 16 local, 17 remote
// ----------------------------------------------------------------
`define MCS_NUM_CHAN        18
`define MCS_CHAN_W          5

`endif

// ---- src/mcs_scan.v ----
`timescale 1ns/1ps
`include "mcs_consts.vh"

module mcs_scan #(
    parameter NUM_CHAN = `MCS_NUM_CHAN,
    parameter CHAN_W   = `MCS_CHAN_W
) (
    // Clock and reset
    input  wire                clk,
    input  wire                rst_b,
    // Control
    input  wire                run,
    input  wire [NUM_CHAN-1:0] chan_en,
    // Converter handshake
    output reg                 conv_start,
    output reg  [CHAN_W-1:0]   conv_channel,
    input  wire                conv_done
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    // Reset parks on the last channel so the first pick is the lowest enabled channel
    localparam integer      LAST_IDX  = NUM_CHAN - 1;
    localparam [CHAN_W-1:0] LAST_CHAN = LAST_IDX[CHAN_W-1:0];

    reg              state;
    reg [CHAN_W-1:0] next_chan;

    // Next enabled channel after cur, wrapping round
    function [CHAN_W-1:0] pick_next;
        input [CHAN_W-1:0]   cur;
        input [NUM_CHAN-1:0] en;
        integer              k;
        integer              idx;
        reg                  found;
        begin
            pick_next = cur;
            found     = 1'b0;
            for (k = 1; k <= NUM_CHAN; k = k + 1) begin
                idx = (cur + k) % NUM_CHAN;
                if (!found && en[idx]) begin
                    pick_next = idx[CHAN_W-1:0];
                    found     = 1'b1;
                end
            end
        end
    endfunction

    always @* begin
        next_chan = pick_next(conv_channel, chan_en);
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            state        <= ST_IDLE;
            conv_start   <= 1'b0;
            conv_channel <= LAST_CHAN;
        end else begin
            conv_start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (run && (|chan_en)) begin
                        conv_channel <= next_chan;
                        conv_start   <= 1'b1;
                        state        <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (conv_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- testbench/mcs_regs_assertions.sv ----
`timescale 1ns/1ps
`include "mcs_consts.vh"
module mcs_regs_assertions #(
    parameter ADDR_W = `MCS_ADDR_W
) (
    // Clock and reset
    input wire              clk,
    input wire              rst_b,
    // Register port
    input wire [ADDR_W-1:0] reg_addr,
    input wire [15:0]       reg_wdata,
    input wire              reg_wr,
    input wire              reg_rd,
    input wire [15:0]       reg_rdata,
    // Outputs and events
    input wire [7:0]        pin_out_level,
    input wire [11:0]       analog_out_on,
    input wire              conv_start,
    input wire [4:0]        conv_channel,
    input wire [7:0]        input_over_trip,
    input wire              alarm
);
    reg  [15:0] wdata_q;
    wire        rd_flags;
    assign rd_flags = reg_rd && reg_addr == 8'h10;
    always @(posedge clk) begin
        wdata_q <= reg_wdata;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    sequence s_clean_read;
        rd_flags && input_over_trip == 8'h00;
    endsequence
    sequence s_any_read;
        rd_flags;
    endsequence
    AST_GPIO_LEVEL: assert property (
        reg_wr && reg_addr == 8'h08 |=> pin_out_level == wdata_q[7:0])
        else $error("gpio levels differ from written byte");
    AST_DAC_POWER: assert property (
        reg_wr && reg_addr == 8'h0c |=> analog_out_on == {wdata_q[13:8], wdata_q[5:0]})
        else $error("dac power outputs differ from written word");
    AST_UPPER_ZERO: assert property (
        reg_rd && (reg_addr >= 8'h08 && reg_addr <= 8'h0b || reg_addr == 8'h10)
        |=> reg_rdata[15:8] == 8'h00) else $error("upper byte not zero");
    AST_UNUSED_ZERO: assert property (
        reg_rd && reg_addr == 8'h0d |=> reg_rdata == 16'h0000)
        else $error("unused slot not zero");
    AST_LOCAL_UPPER: assert property (
        reg_rd && reg_addr == 8'h0e |=> reg_rdata[15:10] == 6'h00)
        else $error("local temperature upper bits set");
    AST_REMOTE_UPPER: assert property (
        reg_rd && reg_addr == 8'h0f |=> reg_rdata[15:10] == 6'h00)
        else $error("remote temperature upper bits set");
    AST_ALARM_DROP: assert property (
        s_clean_read |=> !alarm) else $error("alarm held after status read");
    AST_FLAGS_CLEAR: assert property (
        s_clean_read ##1 s_any_read |=> reg_rdata[7:0] == 8'h00)
        else $error("second status read not cleared");
    AST_CONV_PULSE: assert property (
        conv_start |-> conv_channel <= 5'd17 ##1 !conv_start)
        else $error("conversion start malformed");
endmodule
bind mcs_regs mcs_regs_assertions #(.ADDR_W(ADDR_W)) u_chk (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_out_level(pin_out_level), .analog_out_on(analog_out_on),
    .conv_start(conv_start), .conv_channel(conv_channel),
    .input_over_trip(input_over_trip), .alarm(alarm));

// ---- testbench/mcs_conv_model.sv ----
`timescale 1ns/1ps
module mcs_conv_model #(
    parameter [9:0] LOCAL_VAL  = 10'h1a5,
    parameter [9:0] REMOTE_VAL = 10'h0c3
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_b,
    // Converter handshake
    input  wire       conv_start,
    input  wire [4:0] conv_channel,
    input  wire [3:0] lat,
    output reg        conv_done,
    // Temperature results
    output reg  [9:0] local_temp_data,
    output reg        local_temp_load,
    output reg  [9:0] remote_temp_data,
    output reg        remote_temp_load
);
    reg       busy;
    reg [3:0] cnt;
    reg [4:0] chan;
    // Changes land on the falling edge, clear of the sampling edge
    always @(negedge clk) begin
        conv_done <= 1'b0;
        local_temp_load <= 1'b0;
        remote_temp_load <= 1'b0;
        // Data is meaningless outside a load pulse
        local_temp_data <= ~local_temp_data;
        remote_temp_data <= ~remote_temp_data;
        if (!rst_b) begin
            busy <= 1'b0;
            local_temp_data <= 10'h000;
            remote_temp_data <= 10'h3ff;
        end else if (conv_start) begin
            busy <= 1'b1;
            cnt <= lat;
            chan <= conv_channel;
        end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (busy) begin
            busy <= 1'b0;
            conv_done <= 1'b1;
            if (chan == 5'd16) begin
                local_temp_load <= 1'b1;
                local_temp_data <= LOCAL_VAL;
            end
            if (chan == 5'd17) begin
                remote_temp_load <= 1'b1;
                remote_temp_data <= REMOTE_VAL;
            end
        end
    end
endmodule

// ---- testbench/test_monitor_config_status_regs.sv ----
`timescale 1ns/1ps
module test_monitor_config_status_regs;
    localparam [9:0] LOC = 10'h1a5;
    localparam [9:0] REM = 10'h0c3;
    reg clk, rst_b, reg_wr, reg_rd;
    reg [7:0] reg_addr, input_over_trip;
    reg [15:0] reg_wdata, d;
    reg [3:0] lat;
    reg [4:0] ch, prev;
    wire [15:0] reg_rdata;
    wire [11:0] analog_out_on;
    wire [9:0] local_temp_data, remote_temp_data;
    wire [7:0] pin_out_level;
    wire [4:0] conv_channel;
    wire reg_rvalid, conv_start, conv_done, local_temp_load, remote_temp_load, alarm;
    integer error_cnt, samples_checked, cycles, k;
    mcs_regs dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .pin_out_level(pin_out_level), .analog_out_on(analog_out_on),
        .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
        .local_temp_data(local_temp_data), .local_temp_load(local_temp_load),
        .remote_temp_data(remote_temp_data), .remote_temp_load(remote_temp_load),
        .input_over_trip(input_over_trip), .alarm(alarm));
    mcs_conv_model #(.LOCAL_VAL(LOC), .REMOTE_VAL(REM)) conv (.clk(clk), .rst_b(rst_b),
        .conv_start(conv_start), .conv_channel(conv_channel), .lat(lat),
        .conv_done(conv_done), .local_temp_data(local_temp_data),
        .local_temp_load(local_temp_load), .remote_temp_data(remote_temp_data),
        .remote_temp_load(remote_temp_load));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task end_sim;
        begin
            if (error_cnt == 0 && samples_checked > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            error_cnt = error_cnt + 1;
            end_sim;
        end
    end
    task cmp(input [8*8:1] name, input [15:0] e, input [15:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("Error %0s expected %h seen %h", name, e, g);
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] v);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_wdata = v;
            reg_wr = 1'b1;
            @(negedge clk);
            reg_wr = 1'b0;
        end
    endtask
    task rchk(input [8*8:1] name, input [7:0] a, input [15:0] e);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge clk);
            reg_rd = 1'b0;
            cmp("rvalid", 16'h0001, {15'h0, reg_rvalid});
            cmp(name, e, reg_rdata);
        end
    endtask
    task trip(input [7:0] v);
        begin
            @(negedge clk);
            input_over_trip = v;
            @(negedge clk);
            input_over_trip = 8'h00;
            @(negedge clk);
        end
    endtask
    task next_start;
        begin
            k = 0;
            @(negedge clk);
            while (conv_start !== 1'b1 && k < 200) begin
                @(negedge clk);
                k = k + 1;
            end
            ch = conv_channel;
            cmp("start", 16'h0001, {15'h0, conv_start});
        end
    endtask
    function [4:0] nxt(input [4:0] a, input [17:0] en);
        integer j;
        begin
            nxt = 5'd31;
            for (j = 18; j >= 1; j = j - 1)
                if (en[(a + j) % 18]) nxt = 5'((a + j) % 18);
        end
    endfunction
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset;
        begin
            cmp("pins", 16'h0000, {8'h00, pin_out_level});
            cmp("dac", 16'h0fff, {4'h0, analog_out_on});
            rchk("local", 8'h0e, 16'h0000);
            rchk("remote", 8'h0f, 16'h0000);
            rchk("gpio", 8'h08, 16'h0000);
            rchk("scan_lo", 8'h09, 16'h00ff);
            rchk("scan_hi", 8'h0a, 16'h00ff);
            rchk("scan_tmp", 8'h0b, 16'h00c0);
            rchk("dac_reg", 8'h0c, 16'hffff);
            rchk("unused", 8'h0d, 16'h0000);
            rchk("flags", 8'h10, 16'h0000);
            rchk("mask", 8'h15, 16'h00ff);
            rchk("config", 8'h01, 16'h0001);
            trip(8'h01);
            cmp("alarm", 16'h0000, {15'h0, alarm});
            rchk("flags", 8'h10, 16'h0001);
            cmp("alarm", 16'h0000, {15'h0, alarm});
        end
    endtask
    task t_regs;
        begin
            wr(8'h08, 16'ha55a);
            cmp("pins", 16'h005a, {8'h00, pin_out_level});
            rchk("gpio", 8'h08, 16'h005a);
            wr(8'h0b, 16'hffff);
            rchk("scan_tmp", 8'h0b, 16'h00c0);
            wr(8'h0c, 16'h2d39);
            cmp("dac", {4'h0, 6'h2d, 6'h39}, {4'h0, analog_out_on});
            rchk("dac_reg", 8'h0c, 16'h2d39);
            wr(8'h0d, 16'hffff);
            rchk("unused", 8'h0d, 16'h0000);
            wr(8'h0e, 16'hffff);
            rchk("local", 8'h0e, 16'h0000);
            wr(8'h10, 16'hffff);
            rchk("flags", 8'h10, 16'h0000);
            wr(8'h20, 16'hffff);
            rchk("unmapped", 8'h20, 16'h0000);
        end
    endtask
    task t_scan;
        begin
            wr(8'h09, 16'h0000);
            wr(8'h0a, 16'h0000);
            wr(8'h0b, 16'h0000);
            repeat (20) @(negedge clk);
            d = 16'h0000;
            repeat (40) begin
                @(negedge clk);
                if (conv_start === 1'b1) d = d + 16'h0001;
            end
            cmp("idle", 16'h0000, d);
            lat = 4'h0;
            wr(8'h09, 16'h0004);
            wr(8'h0a, 16'h0008);
            wr(8'h0b, 16'h00c0);
            next_start;
            prev = ch;
            repeat (8) begin
                next_start;
                cmp("chan", {11'h0, nxt(prev, 18'h30804)}, {11'h0, ch});
                prev = ch;
            end
            rchk("local", 8'h0e, {6'h00, LOC});
            rchk("remote", 8'h0f, {6'h00, REM});
        end
    endtask
    task t_alarm;
        begin
            wr(8'h15, 16'h0000);
            trip(8'h05);
            cmp("alarm", 16'h0001, {15'h0, alarm});
            @(negedge clk);
            reg_addr = 8'h10;
            reg_rd = 1'b1;
            @(negedge clk);
            cmp("flags", 16'h0005, reg_rdata);
            cmp("alarm", 16'h0000, {15'h0, alarm});
            @(negedge clk);
            reg_rd = 1'b0;
            cmp("flags2", 16'h0000, reg_rdata);
            wr(8'h15, 16'h00fe);
            trip(8'h02);
            cmp("alarm", 16'h0000, {15'h0, alarm});
            rchk("flags", 8'h10, 16'h0002);
            wr(8'h15, 16'h0000);
            wr(8'h01, 16'h0041);
            trip(8'h80);
            cmp("alarm", 16'h0000, {15'h0, alarm});
            rchk("flags", 8'h10, 16'h0080);
            wr(8'h01, 16'h0001);
            trip(8'h80);
            wr(8'h08, 16'h0000);
            cmp("alarm", 16'h0001, {15'h0, alarm});
            rchk("flags", 8'h10, 16'h0080);
            cmp("alarm", 16'h0000, {15'h0, alarm});
        end
    endtask
    initial begin
        rst_b = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        input_over_trip = 8'h00;
        lat = 4'hf;
        error_cnt = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        t_reset;
        t_regs;
        t_scan;
        t_alarm;
        end_sim;
    end
endmodule
